// >>> hdl/exc_pkg.sv
// Package: exception groups, frame formats, vector codes and request carriers
package exc_pkg;

  // ----------------------------------------------------------------
  // Priority groups
  // ----------------------------------------------------------------
  localparam logic [3:0] GRP_RESET   = 4'h0;
  localparam logic [3:0] GRP_DACCESS = 4'h1;
  localparam logic [3:0] GRP_FPPRE   = 4'h2;
  localparam logic [3:0] GRP_INSTR   = 4'h3;
  localparam logic [3:0] GRP_FPPOST  = 4'h4;
  localparam logic [3:0] GRP_ADDRERR = 4'h5;
  localparam logic [3:0] GRP_TRACE   = 4'h6;
  localparam logic [3:0] GRP_IACCESS = 4'h7;
  localparam logic [3:0] GRP_INTR    = 4'h8;
  localparam logic [3:0] GRP_NONE    = 4'hF;
  localparam int         NUM_SRC     = 13;

  // ----------------------------------------------------------------
  // Frame formats and layout
  // ----------------------------------------------------------------
  localparam logic [3:0]  FMT_FOUR      = 4'h0;
  localparam logic [3:0]  FMT_THROWAWAY = 4'h1;
  localparam logic [3:0]  FMT_SIX       = 4'h2;
  localparam logic [3:0]  FMT_FPPOST    = 4'h3;
  localparam logic [3:0]  FMT_ACCESS    = 4'h7;
  localparam logic [31:0] OFS_STATUS    = 32'h0000_0000;
  localparam logic [31:0] OFS_PC        = 32'h0000_0002;
  localparam logic [31:0] OFS_FMTVEC    = 32'h0000_0006;
  localparam logic [31:0] FRAME4_BYTES  = 32'h0000_0008;
  localparam logic [31:0] FRAME6_BYTES  = 32'h0000_000C;
  localparam logic [31:0] FRAME30_BYTES = 32'h0000_003C;
  localparam int          SR_SUPER_BIT  = 13;
  localparam int          SR_TRACE_BIT  = 15;

  // ----------------------------------------------------------------
  // Vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_RESET    = 8'h00;
  localparam logic [7:0] VEC_ACCESS   = 8'h02;
  localparam logic [7:0] VEC_ADDRERR  = 8'h03;
  localparam logic [7:0] VEC_TRACE    = 8'h09;
  localparam logic [7:0] VEC_FMTERR   = 8'h0E;
  localparam logic [7:0] VEC_FPUNIMP  = 8'h0B;
  localparam logic [7:0] VEC_FPPOST   = 8'h37;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reset;
    logic       dataAccess;
    logic       fpPre;
    logic       execTrap;     // breakpoint, bound check, divide, traps
    logic       preExec;      // illegal, unimplemented line, privilege
    logic       fpUnimpl;
    logic       fpPost;       // only from float_move_instr to memory
    logic       addrErr;
    logic       trace;
    logic       instAccess;
    logic       intr;
    logic [7:0] trapVec;      // vector of the group three condition
    logic [7:0] fpVec;        // vector of the group two condition
    logic [7:0] intrVec;
  } exc_req_s;

  typedef struct packed {
    logic       instrDone;    // current instruction completed
    logic       operandsFetched;
    logic       floatMoveDone;
  } exc_stage_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } stack_rd_s;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;        // 2 = long word, 1 = word
    logic [31:0] data;
  } stack_op_s;

  typedef enum logic [2:0] {
    ACT_NONE, ACT_TAKE, ACT_ABORT, ACT_RESUME
  } exc_action_e;

endpackage : exc_pkg

// >>> hdl/exception_priority_return.sv
// Exception arbitration, interrupt chaining and return-from-exception frame handling
module exception_priority_return (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire exc_pkg::exc_req_s  excReq,
  input  wire exc_pkg::exc_stage_s stage,
  input  wire logic               excReturnInstr,  // exception_return_instr executes
  input  wire logic [31:0]        stackPtr,
  input  wire exc_pkg::stack_rd_s stackRd,
  input  wire logic               procDone,        // vector fetch and stacking finished
  output exc_pkg::stack_op_s      stackOp,
  output logic                    excTake,         // one-cycle pulse
  output logic [3:0]              excGroup,
  output logic [7:0]              excVector,
  output logic                    abortInstr,
  output logic                    restartInstr,
  output logic [2:0]              faultPending,    // fault_status_word flags: trace, post, unimpl
  output logic                    resumeValid,     // pulse: load pc/status and resume
  output logic [31:0]             resumePc,
  output logic [15:0]             statusWord,
  output logic [31:0]             newStackPtr,
  output logic                    formatError,
  output logic                    addrErrOnReturn
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_PROC, ST_RD_SR_PC, ST_RD_FMT, ST_DECIDE
  } ctl_e;

  typedef struct packed {
    ctl_e               st;
    exc_pkg::stack_op_s op;
    logic               take;
    logic [3:0]         grp;
    logic [7:0]         vec;
    logic               abort;
    logic               restart;
    logic [2:0]         pend;
    logic               resume;
    logic [31:0]        pc;
    logic [15:0]        sr;
    logic [31:0]        sp;
    logic [15:0]        fmtWord;
    logic               fmtErr;
    logic               addrErr;
  } state_s;

  state_s r, nxt;

  logic [3:0]  fmt;
  logic [11:0] vecOfs;
  logic        fmtKnown;
  logic [31:0] fBytes;
  logic        oddTrace;

  frame_decode u_decode (
    .fmtVecWord (r.fmtWord),
    .statusWord (r.sr),
    .stackedPc  (r.pc),
    .format     (fmt),
    .vecOffset  (vecOfs),
    .known      (fmtKnown),
    .frameBytes (fBytes),
    .oddPcTrace (oddTrace)
  );

  // ----------------------------------------------------------------
  // Eligibility of each source under its timing condition
  // ----------------------------------------------------------------
  logic tracePend;
  logic accessFlagsFp;
  always_comb begin
    // Trace hidden behind group three or float post
    tracePend = excReq.trace & ~(excReq.execTrap | excReq.preExec
                | excReq.fpUnimpl | excReq.fpPost);
    accessFlagsFp = excReq.fpPost | excReq.fpUnimpl;
  end

  logic [3:0] winGrp;
  logic [7:0] winVec;
  always_comb begin
    winGrp = exc_pkg::GRP_NONE;
    winVec = 8'h00;
    // Highest group first; losers drop and recur on restart, save a chained interrupt and float or trace flags kept by a data access
    if (excReq.reset) begin
      winGrp = exc_pkg::GRP_RESET;
      winVec = exc_pkg::VEC_RESET;
    end else if (excReq.dataAccess) begin
      winGrp = exc_pkg::GRP_DACCESS;
      winVec = exc_pkg::VEC_ACCESS;
    end else if (excReq.fpPre) begin
      winGrp = exc_pkg::GRP_FPPRE;
      winVec = excReq.fpVec;
    end else if (excReq.execTrap | excReq.preExec) begin
      winGrp = exc_pkg::GRP_INSTR;
      winVec = excReq.trapVec;
    end else if (excReq.fpUnimpl & stage.operandsFetched) begin
      winGrp = exc_pkg::GRP_INSTR;
      winVec = exc_pkg::VEC_FPUNIMP;
    end else if (excReq.fpPost & stage.floatMoveDone) begin
      winGrp = exc_pkg::GRP_FPPOST;
      winVec = exc_pkg::VEC_FPPOST;
    end else if (excReq.addrErr & stage.instrDone) begin
      winGrp = exc_pkg::GRP_ADDRERR;
      winVec = exc_pkg::VEC_ADDRERR;
    end else if (tracePend & stage.instrDone) begin
      winGrp = exc_pkg::GRP_TRACE;
      winVec = exc_pkg::VEC_TRACE;
    end else if (excReq.instAccess & stage.instrDone) begin
      winGrp = exc_pkg::GRP_IACCESS;
      winVec = exc_pkg::VEC_ACCESS;
    end else if (excReq.intr & stage.instrDone) begin
      winGrp = exc_pkg::GRP_INTR;
      winVec = excReq.intrVec;
    end
  end

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  always_comb begin
    nxt        = r;
    nxt.take   = 1'b0;
    nxt.resume = 1'b0;
    nxt.op.req = 1'b0;
    nxt.abort  = 1'b0;
    nxt.restart = 1'b0;
    if (excReq.reset) begin
      // Nothing is stacked; all sequences are dropped
      // Vector fetch still follows, so the sequence ends in a resume
      nxt.st     = ST_PROC;
      nxt.take   = 1'b1;
      nxt.grp    = exc_pkg::GRP_RESET;
      nxt.vec    = exc_pkg::VEC_RESET;
      nxt.abort  = 1'b1;
      nxt.pend   = 3'h0;
      nxt.fmtErr = 1'b0;
      nxt.addrErr = 1'b0;
    end else begin
      case (r.st)
        ST_IDLE: begin
          if (winGrp != exc_pkg::GRP_NONE) begin
            nxt.take  = 1'b1;
            nxt.grp   = winGrp;
            nxt.vec   = winVec;
            nxt.abort = (winGrp == exc_pkg::GRP_DACCESS);
            nxt.restart = (winGrp == exc_pkg::GRP_FPPRE);
            nxt.pend  = 3'h0;
            if (winGrp == exc_pkg::GRP_DACCESS) begin
              // Trace flag left as zero when float is flagged
              nxt.pend = {excReq.trace & ~accessFlagsFp,
                          excReq.fpPost, excReq.fpUnimpl & ~excReq.fpPost};
            end
            nxt.st = ST_PROC;
          end else if (excReturnInstr) begin
            nxt.op = '{req: 1'b1, write: 1'b0, addr: stackPtr + exc_pkg::OFS_STATUS,
                       size: 2'h2, data: 32'h0000_0000};
            nxt.sp = stackPtr;
            nxt.fmtErr  = 1'b0;
            nxt.addrErr = 1'b0;
            nxt.st = ST_RD_SR_PC;
          end
        end
        ST_PROC: begin
          if (procDone) begin
            if (excReq.intr & (r.grp != exc_pkg::GRP_INTR)) begin
              // Chain straight into the interrupt handler
              nxt.take = 1'b1;
              nxt.grp  = exc_pkg::GRP_INTR;
              nxt.vec  = excReq.intrVec;
            end else begin
              nxt.resume = 1'b1;
              nxt.st     = ST_IDLE;
            end
          end
        end
        ST_RD_SR_PC: begin
          if (stackRd.valid) begin
            // Long word at sp holds status and pc high half
            nxt.sr = stackRd.data[31:16];
            nxt.pc = {stackRd.data[15:0], 16'h0000};
            nxt.op = '{req: 1'b1, write: 1'b0, addr: r.sp + 32'h0000_0004,
                       size: 2'h2, data: 32'h0000_0000};
            nxt.st = ST_RD_FMT;
          end
        end
        ST_RD_FMT: begin
          if (stackRd.valid) begin
            nxt.pc      = {r.pc[31:16], stackRd.data[31:16]};
            nxt.fmtWord = stackRd.data[15:0];
            nxt.st      = ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          nxt.st = ST_IDLE;
          if (!fmtKnown) begin
            nxt.fmtErr = 1'b1;
            nxt.take   = 1'b1;
            nxt.grp    = exc_pkg::GRP_INSTR;
            nxt.vec    = exc_pkg::VEC_FMTERR;
            nxt.st     = ST_PROC;
          end else if (fmt == exc_pkg::FMT_THROWAWAY) begin
            nxt.sp = r.sp + fBytes;
            nxt.op = '{req: 1'b1, write: 1'b0, addr: r.sp + fBytes,
                       size: 2'h2, data: 32'h0000_0000};
            nxt.st = ST_RD_SR_PC;
          end else if (oddTrace) begin
            nxt.addrErr = 1'b1;
            nxt.sr[exc_pkg::SR_SUPER_BIT] = 1'b1;
            nxt.take = 1'b1;
            nxt.grp  = exc_pkg::GRP_ADDRERR;
            nxt.vec  = exc_pkg::VEC_ADDRERR;
            nxt.st   = ST_PROC;
          end else if (fmt == exc_pkg::FMT_ACCESS && r.pend != 3'h0) begin
            // Frame turns into the pending exception's frame
            nxt.take = 1'b1;
            nxt.sp   = r.sp + fBytes;
            if (r.pend[1]) begin
              nxt.grp = exc_pkg::GRP_FPPOST;
              nxt.vec = exc_pkg::VEC_FPPOST;
            end else if (r.pend[0]) begin
              nxt.grp = exc_pkg::GRP_INSTR;
              nxt.vec = exc_pkg::VEC_FPUNIMP;
            end else begin
              nxt.grp = exc_pkg::GRP_TRACE;
              nxt.vec = exc_pkg::VEC_TRACE;
            end
            nxt.pend = 3'h0;
            nxt.st   = ST_PROC;
          end else begin
            nxt.sp     = r.sp + fBytes;
            nxt.resume = 1'b1;
          end
        end
        default: nxt.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.grp   <= exc_pkg::GRP_NONE;
      r.abort <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state
  // ----------------------------------------------------------------
  assign stackOp         = r.op;
  assign excTake         = r.take;
  assign excGroup        = r.grp;
  assign excVector       = r.vec;
  assign abortInstr      = r.abort;
  assign restartInstr    = r.restart;
  assign faultPending    = r.pend;
  assign resumeValid     = r.resume;
  assign resumePc        = r.pc;
  assign statusWord      = r.sr;
  assign newStackPtr     = r.sp;
  assign formatError     = r.fmtErr;
  assign addrErrOnReturn = r.addrErr;

endmodule : exception_priority_return

// >>> hdl/frame_decode.sv
// Frame format word decoder with status-word odd-pc trace check
module frame_decode (
  input  wire logic [15:0] fmtVecWord,
  input  wire logic [15:0] statusWord,
  input  wire logic [31:0] stackedPc,
  output logic      [3:0]  format,
  output logic      [11:0] vecOffset,
  output logic             known,
  output logic      [31:0] frameBytes,
  output logic             oddPcTrace
);

  always_comb begin
    format     = fmtVecWord[15:12];
    vecOffset  = fmtVecWord[11:0];
    known      = 1'b1;
    frameBytes = exc_pkg::FRAME4_BYTES;
    case (fmtVecWord[15:12])
      exc_pkg::FMT_FOUR:      frameBytes = exc_pkg::FRAME4_BYTES;
      exc_pkg::FMT_THROWAWAY: frameBytes = exc_pkg::FRAME4_BYTES;
      exc_pkg::FMT_SIX:       frameBytes = exc_pkg::FRAME6_BYTES;
      exc_pkg::FMT_FPPOST:    frameBytes = exc_pkg::FRAME6_BYTES;
      exc_pkg::FMT_ACCESS:    frameBytes = exc_pkg::FRAME30_BYTES;
      default:                known      = 1'b0;
    endcase
    oddPcTrace = stackedPc[0] & statusWord[exc_pkg::SR_TRACE_BIT];
  end

endmodule : frame_decode

// >>> test/exception_priority_return_props.sv
// Concurrent checks on the exception arbitration and return block ports
module exception_priority_return_props (
  input wire logic               clk,
  input wire logic               reset,
  input wire exc_pkg::exc_req_s  excReq,
  input wire logic               procDone,
  input wire exc_pkg::stack_rd_s stackRd,
  input wire exc_pkg::stack_op_s stackOp,
  input wire logic               excTake,
  input wire logic [3:0]         excGroup,
  input wire logic [7:0]         excVector,
  input wire logic               abortInstr,
  input wire logic               restartInstr,
  input wire logic [2:0]         faultPending,
  input wire logic               resumeValid,
  input wire logic               formatError,
  input wire logic               addrErrOnReturn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [31:0] reqAddr_r;

  // Last read address, to tie the second frame read to the first
  always_ff @(posedge clk) begin
    if (stackOp.req) begin
      reqAddr_r <= stackOp.addr;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_take: assert property ($rose(excReq.reset) |=> excTake && abortInstr &&
    excGroup == exc_pkg::GRP_RESET && excVector == exc_pkg::VEC_RESET)
    else $error("reset request not taken at once");
  a_access_abort: assert property (excTake && excGroup == exc_pkg::GRP_DACCESS |-> abortInstr)
    else $error("data access take without abort");
  a_fppre_restart: assert property (excTake && excGroup == exc_pkg::GRP_FPPRE |-> restartInstr)
    else $error("float pre take without restart");
  a_intr_chain: assert property (procDone && excReq.intr && excGroup != exc_pkg::GRP_INTR
    |=> excTake && excGroup == exc_pkg::GRP_INTR && excVector == $past(excReq.intrVec))
    else $error("pending interrupt not chained");
  a_done_resume: assert property (procDone && !excReq.intr |=> resumeValid && !excTake)
    else $error("no resume after processing");
  a_long_reads: assert property (stackOp.req |-> stackOp.size == 2'h2 && !stackOp.write)
    else $error("frame access not a long word read");
  a_read_pair: assert property (stackRd.valid ##1 stackOp.req
    |-> stackOp.addr == reqAddr_r + 32'h4)
    else $error("second frame read not four bytes on");
  a_fault_capture: assert property ($changed(faultPending)
    |-> excTake && (excGroup == exc_pkg::GRP_DACCESS || faultPending == 3'h0))
    else $error("pending flags moved outside an access take");
  a_fault_trace: assert property (|faultPending[1:0] |-> !faultPending[2])
    else $error("trace flagged beside a float flag");
  a_fmt_error: assert property (excTake && excGroup == exc_pkg::GRP_INSTR &&
    excVector == exc_pkg::VEC_FMTERR |-> ##[0:1] formatError)
    else $error("format error take without flag");
  a_ret_addrerr: assert property (excTake && excGroup == exc_pkg::GRP_ADDRERR &&
    !$past(excReq.addrErr) |-> ##[0:1] addrErrOnReturn)
    else $error("return address error without flag");

  c_chain: cover property (excTake && excGroup == exc_pkg::GRP_INTR);
  c_resume: cover property (resumeValid);
  c_fmt: cover property ($rose(formatError));
endmodule : exception_priority_return_props

// >>> test/exception_priority_return_test.sv
// Self-checking bench for the exception arbitration and return block
module exception_priority_return_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clk;
  logic                reset;
  exc_pkg::exc_req_s   excReq;
  exc_pkg::exc_stage_s stage;
  logic                excReturnInstr;
  logic [31:0]         stackPtr;
  exc_pkg::stack_rd_s  stackRd;
  logic                procDone;
  exc_pkg::stack_op_s  stackOp;
  logic                excTake, abortInstr, restartInstr, resumeValid;
  logic [3:0]          excGroup;
  logic [7:0]          excVector;
  logic [2:0]          faultPending;
  logic [31:0]         resumePc, newStackPtr;
  logic [15:0]         statusWord;
  logic                formatError, addrErrOnReturn;
  logic [31:0]         seed = 32'h0000_CF30;
  logic [14:0]         tq[$];
  logic [80:0]         rq[$];
  logic [31:0]         mem[logic [31:0]];
  logic [7:0]          tv, fv, iv;
  logic [7:0]          vecOf[11];
  logic [3:0]          grpOf[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h3, 4'h4, 4'h5,
                                     4'h6, 4'h7, 4'h8};
  int                  fail_count = 0;
  int                  num_checks = 0;

  exception_priority_return i_exception_priority_return (
    .clk, .reset, .excReq, .stage, .excReturnInstr, .stackPtr, .stackRd, .procDone,
    .stackOp, .excTake, .excGroup, .excVector, .abortInstr, .restartInstr, .faultPending,
    .resumeValid, .resumePc, .statusWord, .newStackPtr, .formatError, .addrErrOnReturn);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic exc_pkg::exc_req_s mk(input logic [10:0] m);
    exc_pkg::exc_req_s r;
    r = '0;
    {r.reset, r.dataAccess, r.fpPre, r.execTrap, r.preExec, r.fpUnimpl, r.fpPost,
     r.addrErr, r.trace, r.instAccess, r.intr} = m;
    r.trapVec = tv;
    r.fpVec   = fv;
    r.intrVec = iv;
    return r;
  endfunction : mk

  task automatic bad(input string s);
    $display("BAD %0t %s", $time, s);
    fail_count++;
  endtask : bad

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Bounded wait for a take (w=0) or a resume (w=1)
  task automatic waitFor(input bit w);
    int n;
    n = 0;
    // Pulse may already stand when called right after done()
    while (n < 80 && (w ? resumeValid : excTake) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if ((w ? resumeValid : excTake) !== 1'b1) begin
      bad("timeout");
      finish_test();
    end
  endtask : waitFor

  task automatic done();
    repeat (2) @(negedge clk);
    procDone = 1'b1;
    @(negedge clk);
    procDone = 1'b0;
  endtask : done

  // Raise sources; a gated stage stays closed four cycles, with no take allowed
  task automatic exc(input logic [10:0] m, input logic [2:0] st, input logic [3:0] g,
                     input logic [7:0] v, input logic [2:0] f);
    excReq = mk(m);
    if (st != 3'h7) begin
      stage = 3'h0;
      repeat (4) @(negedge clk);
    end
    tq.push_back({f, g, v});
    stage = st;
    waitFor(0);
    excReq = mk((g == 4'h8) ? 11'h000 : (m & 11'h001));
    if (m[0] && g != 4'h8) begin
      tq.push_back({3'h0, 4'h8, iv});
      done();
      waitFor(0);
      excReq = mk(11'h000);
    end
    rq.push_back('0);
    done();
    waitFor(1);
  endtask : exc

  task automatic frame(input logic [31:0] a, input logic [15:0] s, input logic [31:0] pc,
                       input logic [3:0] fm);
    mem[a]         = {s, pc[31:16]};
    mem[a + 32'h4] = {pc[15:0], fm, 12'h018};
  endtask : frame

  // Return; g of F means a plain resume carrying e
  task automatic ret(input logic [31:0] sp, input logic [3:0] g, input logic [7:0] v,
                     input logic [80:0] e);
    stackPtr = sp;
    if (g != 4'hF) tq.push_back({3'h0, g, v});
    excReturnInstr = 1'b1;
    @(negedge clk);
    excReturnInstr = 1'b0;
    if (g != 4'hF) begin
      waitFor(0);
      if (g == 4'h5 && statusWord[exc_pkg::SR_SUPER_BIT] !== 1'b1) bad("supervisor bit");
      rq.push_back('0);
      done();
    end else begin
      rq.push_back(e);
    end
    waitFor(1);
  endtask : ret

  // ----------------------------------------------------------------
  // Stack responder: random latency, junk data when idle
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] a;
    stackRd = '0;
    forever begin
      @(negedge clk);
      stackRd.valid = 1'b0;
      stackRd.data  = rnd();
      if (stackOp.req === 1'b1) begin
        a = stackOp.addr;
        repeat (rnd() % 3) @(negedge clk);
        stackRd.valid = 1'b1;
        stackRd.data  = mem[a];
      end
    end
  end

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    logic [14:0] et;
    logic [80:0] er;
    if (reset === 1'b0 && excTake === 1'b1) begin
      num_checks++;
      et = (tq.size() != 0) ? tq.pop_front() : 15'h7FFF;
      if ({excGroup, excVector} !== et[11:0]) bad("take group or vector");
      if (et[11:8] == 4'h1 && faultPending !== et[14:12]) bad("pending flags");
    end
    if (reset === 1'b0 && resumeValid === 1'b1) begin
      num_checks++;
      er = (rq.size() != 0) ? rq.pop_front() : {1'b1, 80'h0};
      if (er[80] && {resumePc, newStackPtr, statusWord} !== er[79:0]) bad("resume");
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] sp, pc, r;
    logic [15:0] s;
    excReq = '0;
    stage = '0;
    excReturnInstr = 1'b0;
    stackPtr = '0;
    procDone = 1'b0;
    reset = 1'b1;
    r = rnd();
    tv = {2'h2, r[5:0]};   // Kept clear of the format error vector
    fv = r[15:8];
    iv = r[23:16];
    vecOf = '{8'h00, 8'h02, fv, tv, tv, 8'h0B, 8'h37, 8'h03, 8'h09, 8'h02, iv};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    exc(11'h600, 3'h7, 4'h0, 8'h00, 3'h0);
    exc(11'h214, 3'h7, 4'h1, 8'h02, 3'h2);
    exc(11'h204, 3'h7, 4'h1, 8'h02, 3'h4);
    exc(11'h224, 3'h7, 4'h1, 8'h02, 3'h1);
    frame(32'h0000_1000, 16'h2700, 32'h0000_2000, 4'h7);
    ret(32'h0000_1000, 4'h3, 8'h0B, '0);
    for (int i = 2; i < 11; i++) exc(11'h7FF >> i, 3'h7, grpOf[i], vecOf[i], 3'h0);
    exc(11'h020, 3'h2, 4'h3, 8'h0B, 3'h0);
    exc(11'h010, 3'h1, 4'h4, 8'h37, 3'h0);
    exc(11'h008, 3'h4, 4'h5, 8'h03, 3'h0);
    exc(11'h004, 3'h4, 4'h6, 8'h09, 3'h0);
    exc(11'h001, 3'h4, 4'h8, iv, 3'h0);
    for (int k = 0; k < 4; k++) begin
      sp = (rnd() & 32'h00FF_FFF0) | 32'h0001_0000;
      s = rnd();
      pc = rnd() & 32'hFFFF_FFFE;
      r = rnd();
      frame(sp, s, pc, 4'h0);
      ret(sp, 4'hF, 8'h00, {1'b1, pc, sp + 32'h8, s});
      frame(sp, r[31:16], r, 4'h1);
      frame(sp + 32'h8, s, pc, 4'h0);
      ret(sp, 4'hF, 8'h00, {1'b1, pc, sp + 32'h10, s});
      frame(sp, s, pc, 4'h8 | r[2:0]);
      ret(sp, 4'h3, 8'h0E, '0);
      frame(sp, s | 16'h8000, pc | 32'h1, 4'h0);
      ret(sp, 4'h5, 8'h03, '0);
    end
    repeat (5) @(negedge clk);
    if (tq.size() != 0 || rq.size() != 0) bad("missing result");
    finish_test();
  end
endmodule : exception_priority_return_test

bind exception_priority_return exception_priority_return_props i_exception_priority_return_props (
  .clk, .reset, .excReq, .procDone, .stackRd, .stackOp, .excTake, .excGroup, .excVector,
  .abortInstr, .restartInstr, .faultPending, .resumeValid, .formatError, .addrErrOnReturn);
